// ==== rtl/acq_pkg.sv ====
// shared constants and carrier types for the acquisition register block
package acq_pkg;
    localparam int          ADDR_W          = 5;
    localparam int          RESULT_W        = 12;
    localparam int          CHAN_W          = 4;
    localparam int          RANGE_W         = 4;
    localparam int          FIFO_DEPTH      = 1024;
    // port offsets
    localparam logic [4:0]  OFF_RESULT_LOW  = 5'h00;
    localparam logic [4:0]  OFF_RESULT_HIGH = 5'h01;
    localparam logic [4:0]  OFF_STATUS      = 5'h08;
    localparam logic [4:0]  OFF_CONTROL     = 5'h09;
    localparam logic [4:0]  OFF_PACER       = 5'h0A;
    localparam logic [4:0]  OFF_TIMER_FIRST = 5'h0C;
    localparam logic [4:0]  OFF_TIMER_LAST  = 5'h0F;
    localparam logic [4:0]  OFF_BUF_LOW     = 5'h17;
    localparam logic [4:0]  OFF_BUF_HIGH    = 5'h18;
    localparam logic [4:0]  OFF_BUF_FLAGS   = 5'h19;
    // field positions
    localparam int          ST_BUSY_BIT     = 7;
    localparam int          ST_MUX_BIT      = 5;
    localparam int          ST_VALID_BIT    = 4;
    localparam int          CTL_TRIG_LO_BIT = 0;
    localparam int          CTL_TRIG_HI_BIT = 1;
    localparam int          CTL_DMA_REQUEST_ENABLE_BIT    = 2;
    localparam int          PACER_DIS_BIT   = 0;
    localparam int          BUF_EMPTY_BIT   = 0;
    localparam int          BUF_HALF_BIT    = 1;
    localparam int          BUF_FULL_BIT    = 2;
    // reset values and the zero read byte
    localparam logic [7:0]  CONTROL_RESET   = 8'h00;
    localparam logic [7:0]  PACER_RESET     = 8'h01;
    localparam logic [7:0]  BYTE_ZERO       = 8'h00;
    // trigger select codes
    localparam logic [1:0]  TRIG_EXTERNAL   = 2'h2;
    localparam logic [1:0]  TRIG_PACER      = 2'h3;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [4:0]        addr;
        logic [7:0]        wdata;
    } acq_io_req_t;

    typedef struct packed {
        logic              done;
        logic [11:0]       result;
        logic [3:0]        channel;
    } acq_conv_t;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [1:0]        addr;
        logic [7:0]        wdata;
    } acq_timer_req_t;
endpackage

// ==== rtl/acq_fifo.sv ====
// result buffer: first-in first-out store with empty, half and full flags
`timescale 1ns/100ps
module acq_fifo
    import acq_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic             push,
    input  wire logic [WIDTH-1:0] push_data,
    input  wire logic             pop,
    input  wire logic             clear,
    output logic      [WIDTH-1:0] head,
    output logic                  empty,
    output logic                  half,
    output logic                  full
);
    localparam int PTR_W = $clog2(DEPTH);

    typedef struct packed {
        logic [PTR_W-1:0] wptr;
        logic [PTR_W-1:0] rptr;
        logic [PTR_W:0]   count;
        logic             empty;
        logic             half;
        logic             full;
    } acq_fifo_state_t;

    localparam logic [PTR_W:0] COUNT_FULL = (PTR_W+1)'(DEPTH);
    localparam logic [PTR_W:0] COUNT_HALF = (PTR_W+1)'(DEPTH / 2);

    logic [WIDTH-1:0] mem [DEPTH];
    acq_fifo_state_t  state;
    acq_fifo_state_t  next_state;
    logic             do_push;
    logic             do_pop;

    // a full store refuses the push, older entries survive
    assign do_push = push && !state.full && !clear;
    assign do_pop  = pop && !state.empty && !clear;
    assign head    = mem[state.rptr];
    assign empty   = state.empty;
    assign half    = state.half;
    assign full    = state.full;

    always_comb begin
        next_state = state;
        if (clear) begin
            next_state.wptr  = '0;
            next_state.rptr  = '0;
            next_state.count = '0;
        end else begin
            if (do_push) begin
                next_state.wptr = state.wptr + 1'b1;
            end
            if (do_pop) begin
                next_state.rptr = state.rptr + 1'b1;
            end
            if (do_push && !do_pop) begin
                next_state.count = state.count + 1'b1;
            end else if (do_pop && !do_push) begin
                next_state.count = state.count - 1'b1;
            end
        end
        next_state.empty = (next_state.count == '0);
        next_state.half  = (next_state.count >= COUNT_HALF);
        next_state.full  = (next_state.count == COUNT_FULL);
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state       <= '0;
            state.empty <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    // storage carries no reset, only pointers define contents
    always_ff @(posedge core_clk) begin
        if (do_push) begin
            mem[state.wptr] <= push_data;
        end
    end
endmodule

// ==== rtl/acq_regs.sv ====
// acquisition register bank: trigger, pacer, result, status and result buffer
`timescale 1ns/100ps
// Behaviour
// - trigger from software if select high bit 0, external at 10, pacer at 11.
// - pacer runs while pacer_disable is 0, stopped while it is 1.
// - four byte ports pass reads and writes through to the pacer timer.
// - results with channel are buffered in a 1024-word first-in first-out store.
// - buffered low port gives result 3..0 and channel; high port result 11..4.
// - buffer flags port shows empty, half-full and full.
// - any write to the buffer flags port empties the buffer.
// - result low nibble sits in low port bits 7..4, high byte in high port.
// - low result port bits 3..0 hold the result's source channel.
// - status port: busy bit 7, input config bit 5, valid bit 4, next channel.
// - each channel keeps its own range code, applied when converted.
// - any write to the status port clears only the data-valid flag.
// - busy reads 1 during conversion, 0 when idle.
// - while idle, the channel status bits give the next channel.
module acq_regs
    import acq_pkg::*;
(
    input  wire logic                core_clk,
    input  wire logic                rst_n,
    input  wire acq_io_req_t         io_req,
    output logic      [7:0]          io_rdata,
    output logic                     io_rvalid,
    input  wire acq_conv_t           conv,
    input  wire logic                conv_busy,
    input  wire logic [CHAN_W-1:0]   next_channel,
    input  wire logic                input_config_pin,
    input  wire logic                ext_trigger_pin,
    input  wire logic                pacer_tick,
    output logic                     conv_start,
    output logic      [RANGE_W-1:0]  range_code,
    output logic                     pacer_run,
    output logic                     dma_request_enable,
    output acq_timer_req_t           timer_req,
    input  wire logic [7:0]          timer_rdata
);
    typedef struct packed {
        logic [7:0]          control;
        logic [7:0]          pacer_gate;
        logic                pacer_run;
        logic [11:0]         conversion_result;
        logic [3:0]          result_channel;
        logic                data_valid;
        logic [1:0]          ext_sync;
        logic                ext_prev;
        logic                mux_meta;
        logic                mux_sync;
        logic [7:0]          rdata;
        logic                rvalid;
        logic                timer_pending;
        logic                conv_start;
        logic [RANGE_W-1:0]  range_code;
        acq_timer_req_t      timer_req;
    } acq_state_t;

    acq_state_t          state;
    acq_state_t          next_state;
    logic [RANGE_W-1:0]  range_ram [1 << CHAN_W];
    logic [15:0]         buf_head;
    logic                buf_empty;
    logic                buf_half;
    logic                buf_full;
    logic                buf_pop;
    logic                buf_clear;
    logic                range_write;
    logic [1:0]          trig_sel;
    logic                trigger;

    function automatic logic hit(input acq_io_req_t r, input logic [4:0] off);
        return r.addr == off;
    endfunction

    // one byte of result lower nibble beside the channel
    function automatic logic [7:0] low_byte(input logic [11:0] res, input logic [3:0] ch);
        return {res[3:0], ch};
    endfunction

    assign trig_sel  = {state.control[CTL_TRIG_HI_BIT], state.control[CTL_TRIG_LO_BIT]};
    assign buf_pop   = io_req.rd && hit(io_req, OFF_BUF_HIGH);
    assign buf_clear = io_req.wr && hit(io_req, OFF_BUF_FLAGS);
    // range codes are loaded through the result high port write
    assign range_write = io_req.wr && hit(io_req, OFF_RESULT_HIGH);

    always_comb begin
        trigger = 1'b0;
        if (!trig_sel[1]) begin
            trigger = io_req.wr && hit(io_req, OFF_RESULT_LOW);
        end else if (trig_sel == TRIG_EXTERNAL) begin
            trigger = state.ext_sync[1] && !state.ext_prev;
        end else if (trig_sel == TRIG_PACER) begin
            trigger = pacer_tick && !state.pacer_gate[PACER_DIS_BIT];
        end
    end

    always_comb begin
        next_state = state;
        // pin inputs: the first stage feeds only the second
        next_state.ext_sync = {state.ext_sync[0], ext_trigger_pin};
        next_state.ext_prev = state.ext_sync[1];
        next_state.mux_meta = input_config_pin;
        next_state.mux_sync = state.mux_meta;
        next_state.conv_start = trigger;
        // conversion uses the code of the channel it will take next
        next_state.range_code = range_ram[next_channel];
        if (conv.done) begin
            next_state.conversion_result = conv.result;
            next_state.result_channel    = conv.channel;
        end
        // completion wins over a clear in the same cycle
        if (io_req.wr && hit(io_req, OFF_STATUS)) begin
            next_state.data_valid = 1'b0;
        end
        if (conv.done) begin
            next_state.data_valid = 1'b1;
        end
        if (io_req.wr && hit(io_req, OFF_CONTROL)) begin
            next_state.control = io_req.wdata;
        end
        if (io_req.wr && hit(io_req, OFF_PACER)) begin
            next_state.pacer_gate = io_req.wdata;
        end
        // registered copy so the output comes straight from a flop
        next_state.pacer_run = !next_state.pacer_gate[PACER_DIS_BIT];
        next_state.timer_req = '0;
        if ((io_req.wr || io_req.rd) && io_req.addr >= OFF_TIMER_FIRST
                && io_req.addr <= OFF_TIMER_LAST) begin
            next_state.timer_req.wr    = io_req.wr;
            next_state.timer_req.rd    = io_req.rd;
            next_state.timer_req.addr  = io_req.addr[1:0];
            next_state.timer_req.wdata = io_req.wdata;
        end
        // timer answers one cycle after its registered strobe, so its read is late by two
        next_state.timer_pending = state.timer_req.rd;
        next_state.rvalid = 1'b0;
        if (state.timer_pending) begin
            next_state.rdata  = timer_rdata;
            next_state.rvalid = 1'b1;
        end
        if (io_req.rd && !next_state.timer_req.rd) begin
            next_state.rvalid = 1'b1;
            unique case (io_req.addr)
                OFF_RESULT_LOW: begin
                    next_state.rdata = low_byte(state.conversion_result,
                                                state.result_channel);
                end
                OFF_RESULT_HIGH: begin
                    next_state.rdata = state.conversion_result[11:4];
                end
                OFF_STATUS: begin
                    next_state.rdata = BYTE_ZERO;
                    next_state.rdata[ST_BUSY_BIT]  = conv_busy;
                    next_state.rdata[ST_MUX_BIT]   = state.mux_sync;
                    next_state.rdata[ST_VALID_BIT] = state.data_valid;
                    next_state.rdata[CHAN_W-1:0]   = next_channel;
                end
                OFF_CONTROL: begin
                    next_state.rdata = state.control;
                end
                OFF_PACER: begin
                    next_state.rdata = state.pacer_gate;
                end
                OFF_BUF_LOW: begin
                    next_state.rdata = low_byte(buf_head[15:4], buf_head[3:0]);
                end
                OFF_BUF_HIGH: begin
                    next_state.rdata = buf_head[15:8];
                end
                OFF_BUF_FLAGS: begin
                    next_state.rdata = BYTE_ZERO;
                    next_state.rdata[BUF_EMPTY_BIT] = buf_empty;
                    next_state.rdata[BUF_HALF_BIT]  = buf_half;
                    next_state.rdata[BUF_FULL_BIT]  = buf_full;
                end
                default: begin
                    next_state.rdata = BYTE_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state            <= '0;
            state.control    <= CONTROL_RESET;
            state.pacer_gate <= PACER_RESET;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge core_clk) begin
        if (range_write) begin
            range_ram[next_channel] <= io_req.wdata[RANGE_W-1:0];
        end
    end

    acq_fifo #(
        .WIDTH (16),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .push      (conv.done),
        .push_data ({conv.result, conv.channel}),
        .pop       (buf_pop),
        .clear     (buf_clear),
        .head      (buf_head),
        .empty     (buf_empty),
        .half      (buf_half),
        .full      (buf_full)
    );

    assign io_rdata           = state.rdata;
    assign io_rvalid          = state.rvalid;
    assign conv_start         = state.conv_start;
    assign range_code         = state.range_code;
    assign pacer_run          = state.pacer_run;
    assign dma_request_enable = state.control[CTL_DMA_REQUEST_ENABLE_BIT];
    assign timer_req          = state.timer_req;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    property p_soft_trigger;
        io_req.wr && hit(io_req, OFF_RESULT_LOW) && !trig_sel[1] |=> conv_start;
    endproperty
    a_soft_trigger: assert property (p_soft_trigger) else $error("software trigger lost");

    property p_pacer_stopped;
        pacer_tick && state.pacer_gate[PACER_DIS_BIT] && trig_sel == TRIG_PACER
            |=> !conv_start;
    endproperty
    a_pacer_stopped: assert property (p_pacer_stopped) else $error("pacer ran while disabled");

    property p_timer_pass;
        io_req.wr && hit(io_req, OFF_TIMER_FIRST) |=> timer_req.wr && timer_req.addr == 2'h0;
    endproperty
    a_timer_pass: assert property (p_timer_pass) else $error("timer write not passed");

    property p_flush;
        buf_clear |=> buf_empty && !buf_full && !buf_half
            ##1 (buf_empty || $past(conv.done));
    endproperty
    a_flush: assert property (p_flush) else $error("flush left entries");

    property p_valid_set;
        conv.done |=> state.data_valid;
    endproperty
    a_valid_set: assert property (p_valid_set) else $error("data valid not set");

    property p_valid_clear;
        io_req.wr && hit(io_req, OFF_STATUS) && !conv.done |=> !state.data_valid
            && $stable(state.control);
    endproperty
    a_valid_clear: assert property (p_valid_clear) else $error("status write wrong");

    property p_high_byte;
        conv.done ##1 (io_req.rd && hit(io_req, OFF_RESULT_HIGH)) |=>
            io_rvalid && io_rdata == $past(conv.result[11:4], 2);
    endproperty
    a_high_byte: assert property (p_high_byte) else $error("result high byte wrong");

    property p_status_busy;
        io_req.rd && hit(io_req, OFF_STATUS) |=>
            io_rdata[ST_BUSY_BIT] == $past(conv_busy)
            && io_rdata[CHAN_W-1:0] == $past(next_channel);
    endproperty
    a_status_busy: assert property (p_status_busy) else $error("status read wrong");

    property p_full_hold;
        buf_full && conv.done && !buf_pop && !buf_clear |=> buf_full;
    endproperty
    a_full_hold: assert property (p_full_hold) else $error("full store changed");
endmodule

// ==== verif/acq_host_model.sv ====
// host bus model: byte port reads and writes toward the acquisition registers
`timescale 1ns/100ps
module acq_host_model
    import acq_pkg::*;
(
    input  wire logic        core_clk,
    output acq_io_req_t      io_req,
    input  wire logic [7:0]  io_rdata,
    input  wire logic        io_rvalid,
    output logic             timed_out
);
    logic dma_programmed;

    initial begin
        io_req = '0;
        timed_out = 1'b0;
        dma_programmed = 1'b0;
    end

    // entered just after a rising edge; strobe held across exactly one edge
    task automatic bus_write(input logic [4:0] addr, input logic [7:0] data);
        io_req.addr = addr;
        io_req.wdata = data;
        io_req.wr = 1'b1;
        @(posedge core_clk);
        #1;
        io_req.wr = 1'b0;
        io_req.wdata = ~data;
        @(posedge core_clk);
        #1;
    endtask

    task automatic bus_read(input logic [4:0] addr, output logic [7:0] data);
        int waited;
        io_req.addr = addr;
        io_req.rd = 1'b1;
        @(posedge core_clk);
        #1;
        io_req.rd = 1'b0;
        waited = 0;
        // timer reads answer late; waiting here also spaces the next request
        while (io_rvalid !== 1'b1 && waited < 6) begin
            @(posedge core_clk);
            #1;
            waited++;
        end
        data = io_rdata;
        if (io_rvalid !== 1'b1) timed_out = 1'b1;
        @(posedge core_clk);
        #1;
    endtask

    // dma setup is only marked by the dma_programmed flag first, then the enable bit is written
    task automatic enable_dma(input logic [7:0] ctl);
        dma_programmed = 1'b1;
        bus_write(OFF_CONTROL, ctl | (8'h01 << CTL_DMA_REQUEST_ENABLE_BIT));
    endtask
endmodule

// ==== verif/tb_top.sv ====
// self-checking bench for the acquisition register bank
`timescale 1ns/100ps
module tb_top
    import acq_pkg::*;
;
    logic           core_clk = 1'b0;
    logic           rst_n = 1'b0;
    acq_io_req_t    io_req;
    logic [7:0]     io_rdata;
    logic           io_rvalid;
    acq_conv_t      conv = '0;
    logic           conv_busy = 1'b1;
    logic [3:0]     next_channel = 4'h5;
    logic           input_config_pin = 1'b1;
    logic           ext_trigger_pin = 1'b0;
    logic           pacer_tick = 1'b0;
    logic           conv_start;
    logic [3:0]     range_code;
    logic           pacer_run;
    logic           dma_request_enable;
    acq_timer_req_t timer_req;
    logic [7:0]     timer_rdata = 8'h00;
    logic           timed_out;
    logic [9:0]     timer_wr_seen = '0;
    logic [31:0]    rnd = 32'h000110A4;
    logic [15:0]    q[$];
    logic [7:0]     b0;
    logic [7:0]     b1;
    logic [3:0]     codes[2];
    int             starts = 0;
    int             s;
    int             fails = 0;
    int             tests_run = 0;

    always #2 core_clk = ~core_clk;

    acq_regs uut (.core_clk(core_clk), .rst_n(rst_n), .io_req(io_req), .io_rdata(io_rdata),
        .io_rvalid(io_rvalid), .conv(conv), .conv_busy(conv_busy), .next_channel(next_channel),
        .input_config_pin(input_config_pin), .ext_trigger_pin(ext_trigger_pin),
        .pacer_tick(pacer_tick), .conv_start(conv_start), .range_code(range_code),
        .pacer_run(pacer_run), .dma_request_enable(dma_request_enable),
        .timer_req(timer_req), .timer_rdata(timer_rdata));

    acq_host_model host (.core_clk(core_clk), .io_req(io_req), .io_rdata(io_rdata),
        .io_rvalid(io_rvalid), .timed_out(timed_out));

    // timer stand-in: answers one cycle after a read, scrambles otherwise
    always @(posedge core_clk) begin
        timer_rdata <= (timer_req.rd === 1'b1) ? {6'h15, timer_req.addr} : ~timer_rdata;
        if (timer_req.wr === 1'b1) timer_wr_seen <= {timer_req.addr, timer_req.wdata};
        if (conv_start === 1'b1) starts <= starts + 1;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    function automatic logic [7:0] flags_exp(input int n);
        return {5'h00, n == FIFO_DEPTH, n >= FIFO_DEPTH / 2, n == 0};
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rd_chk(input logic [4:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        host.bus_read(addr, d);
        check({8'h00, d}, {8'h00, exp});
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // back-to-back completions; the buffer model drops what exceeds the depth
    task automatic push(input int n);
        for (int i = 0; i < n; i++) begin
            rnd = lfsr_next(rnd);
            conv.done = 1'b1;
            conv.result = rnd[11:0];
            conv.channel = rnd[15:12];
            if (q.size() < FIFO_DEPTH) q.push_back(rnd[15:0]);
            cycles(1);
        end
        conv.done = 1'b0;
        conv.result = ~conv.result;
    endtask

    task automatic pop_chk();
        logic [15:0] e;
        e = q.pop_front();
        host.bus_read(OFF_BUF_LOW, b0);
        host.bus_read(OFF_BUF_HIGH, b1);
        check({b1, b0}, {e[11:0], e[15:12]});
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge timed_out) begin
        fails++;
        report_and_stop();
    end

    initial begin
        cycles(4);
        rst_n = 1'b1;
        rd_chk(OFF_CONTROL, CONTROL_RESET);
        rd_chk(OFF_PACER, PACER_RESET);
        check({15'h0, pacer_run}, 16'h0000);
        check({15'h0, dma_request_enable}, 16'h0000);
        rd_chk(OFF_BUF_FLAGS, flags_exp(0));
        rd_chk(5'h05, BYTE_ZERO);
        rd_chk(OFF_STATUS, 8'hA5);
        conv_busy = 1'b0;
        rd_chk(OFF_STATUS, 8'h25);
        host.bus_write(OFF_PACER, 8'h00);
        check({15'h0, pacer_run}, 16'h0001);
        // every select code, each fed all three trigger sources
        for (int m = 0; m < 4; m++) begin
            host.bus_write(OFF_CONTROL, 8'(m));
            s = starts;
            host.bus_write(OFF_RESULT_LOW, 8'h00);
            ext_trigger_pin = 1'b1;
            cycles(8);
            pacer_tick = 1'b1;
            cycles(1);
            pacer_tick = 1'b0;
            cycles(4);
            ext_trigger_pin = 1'b0;
            cycles(8);
            check(16'(starts - s), 16'h0001);
        end
        host.bus_write(OFF_PACER, 8'h01);
        s = starts;
        pacer_tick = 1'b1;
        cycles(1);
        pacer_tick = 1'b0;
        cycles(4);
        check({pacer_run, 15'h0} | 16'(starts - s), 16'h0000);
        host.enable_dma(8'h00);
        check({15'h0, dma_request_enable}, 16'h0001);
        rd_chk(OFF_CONTROL, 8'h04);
        for (int k = 0; k < 2; k++) begin
            rnd = lfsr_next(rnd);
            codes[k] = rnd[3:0];
            next_channel = 4'(k * 7 + 3);
            host.bus_write(OFF_RESULT_HIGH, {4'h0, codes[k]});
        end
        for (int k = 0; k < 2; k++) begin
            next_channel = 4'(k * 7 + 3);
            cycles(3);
            check({12'h0, range_code}, {12'h0, codes[k]});
        end
        host.bus_write(OFF_BUF_FLAGS, 8'h00);
        push(3);
        // high byte first, right behind the completion
        host.bus_read(OFF_RESULT_HIGH, b1);
        host.bus_read(OFF_RESULT_LOW, b0);
        check({b1, b0}, {q[2][11:0], q[2][15:12]});
        rd_chk(OFF_STATUS, {3'h1, 1'b1, next_channel});
        host.bus_write(OFF_STATUS, 8'hFF);
        rd_chk(OFF_STATUS, {3'h1, 1'b0, next_channel});
        input_config_pin = 1'b0;
        cycles(3);
        rd_chk(OFF_STATUS, {3'h0, 1'b0, next_channel});
        rd_chk(OFF_BUF_FLAGS, flags_exp(3));
        host.bus_read(OFF_BUF_LOW, b0);
        repeat (3) pop_chk();
        rd_chk(OFF_BUF_FLAGS, flags_exp(0));
        push(511);
        rd_chk(OFF_BUF_FLAGS, flags_exp(511));
        push(1);
        rd_chk(OFF_BUF_FLAGS, flags_exp(512));
        push(513);
        rd_chk(OFF_BUF_FLAGS, flags_exp(1024));
        pop_chk();
        rd_chk(OFF_BUF_FLAGS, flags_exp(1023));
        rnd = lfsr_next(rnd);
        host.bus_write(OFF_BUF_FLAGS, rnd[7:0]);
        q.delete();
        rd_chk(OFF_BUF_FLAGS, flags_exp(0));
        push(1);
        pop_chk();
        host.bus_write(5'h0D, 8'h5A);
        cycles(2);
        check({6'h00, timer_wr_seen}, {6'h00, 2'h1, 8'h5A});
        rd_chk(5'h0E, {6'h15, 2'h2});
        report_and_stop();
    end
endmodule
